// *** spi_port_params.svh ***
// constants of the clock-stop serial port: offsets, fields, reset values, counts
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

`define SPI_WORD_BITS 8
`define SPI_BITCNT_BITS 4
`define SPI_LAST_BIT 4'h7
`define SPI_FULL_WORD 4'h8
`define SPI_EDGE_BITS 5
`define SPI_LAST_EDGE 5'h0f
`define SPI_PHASE_BITS 9
`define SPI_ONE_TICK 9'h001
`define SPI_SYNC_BITS 5

`define AXI_ADDR_BITS 8
`define OFS_CONTROL 8'h00
`define OFS_DIVIDER 8'h04
`define OFS_TXDATA 8'h08
`define OFS_RXDATA 8'h0c
`define OFS_STATUS 8'h10
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CTL_BITS 11
`define CTL_RESET 11'h07c
`define CTL_ENABLE 0
`define CTL_MODE_DELAY 1
`define CTL_MODE_STOP 2
`define CTL_TX_CLK_POL 3
`define CTL_DIV_IN_SEL 4
`define CTL_RX_FS_POL 5
`define CTL_TX_FS_POL 6
`define CTL_TX_CLK_DIR 7
`define CTL_TX_FS_DIR 8
`define CTL_RX_CLK_DIR 9
`define CTL_RX_FS_DIR 10
`define DIV_BITS 8
`define DIV_RESET 8'h01

`define STS_OVERRUN 3
`define STS_UNDERRUN 4

`endif

// *** spi_port_pkg.sv ***
// types shared by the clock-stop serial port
`include "spi_port_params.svh"

package spi_port_pkg;
    typedef logic [`SPI_WORD_BITS-1:0] word_t;
    typedef logic [`SPI_PHASE_BITS-1:0] phase_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_TAIL = 2'b10
    } master_state_t;
endpackage

// *** spi_sync3.sv ***
// three-stage input synchroniser with agreement filter on the last two stages
`timescale 1ns/1ps

module spi_sync3 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // asynchronous levels in, filtered levels out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] s1_d, s2_d, s3_d, out_d;

    always_comb begin
        s1_d = din;
        s2_d = s1_q;
        s3_d = s2_q;
        out_d = out_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule // spi_sync3

// *** spi_word_buffer.sv ***
// two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps

module spi_word_buffer
    import spi_port_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // filling side
    input wire logic inValid,
    output logic inReady,
    input wire word_t inData,
    // draining side
    output logic outValid,
    input wire logic outReady,
    output word_t outData
);
    word_t mem_q [2];
    word_t mem_d [2];
    logic wrPtr_q, rdPtr_q, wrPtr_d, rdPtr_d;
    logic [1:0] count_q, count_d;
    logic push, pop;

    assign inReady = (count_q != 2'h2);
    assign outValid = (count_q != 2'h0);
    assign outData = mem_q[rdPtr_q];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    always_comb begin
        mem_d = mem_q;
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        count_d = count_q;
        if (push) begin
            mem_d[wrPtr_q] = inData;
            wrPtr_d = ~wrPtr_q;
        end
        if (pop) begin
            rdPtr_d = ~rdPtr_q;
        end
        if (push && !pop) begin
            count_d = count_q + 2'h1;
        end else if (pop && !push) begin
            count_d = count_q - 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wrPtr_q <= 1'b0;
            rdPtr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end
endmodule // spi_word_buffer

// *** spi_port.sv ***
// clock-stop serial port, master or slave, with AXI4-Lite register access
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "spi_port_params.svh"

module spi_port
    import spi_port_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // axi4-lite write address and data
    input wire logic [`AXI_ADDR_BITS-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [`AXI_ADDR_BITS-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // external divider input clock pin
    input wire logic sampleClockPin,
    // bit clock pin
    input wire logic txBitClockIn,
    output logic txBitClockOut,
    output logic txBitClockOe,
    // frame sync pins
    input wire logic txFrameSyncIn,
    output logic txFrameSyncOut,
    output logic txFrameSyncOe,
    input wire logic rxFrameSyncIn,
    output logic rxFrameSyncOut,
    output logic rxFrameSyncOe,
    // serial data pins
    input wire logic serialInPin,
    output logic serialOutPin,
    output logic serialOutOe
);
    ////////////////////////////////////////////////////////////////////////////
    // configuration fields
    logic [`CTL_BITS-1:0] ctl_q, ctl_d;
    logic [`DIV_BITS-1:0] div_q, div_d;
    logic overrun_q, overrun_d, underrun_q, underrun_d;
    logic enable, delayMode, stopMode, isMaster, runMaster;

    assign enable = ctl_q[`CTL_ENABLE];
    assign delayMode = ctl_q[`CTL_MODE_DELAY];
    assign stopMode = ctl_q[`CTL_MODE_STOP];
    assign isMaster = ctl_q[`CTL_TX_CLK_DIR];
    assign runMaster = enable & stopMode & isMaster;

    ////////////////////////////////////////////////////////////////////////////
    // buffers
    logic txInValid, txInReady, txOutValid, txOutReady;
    logic rxInValid, rxInReady, rxOutValid, rxOutReady;
    word_t txInData, txOutData, rxInData, rxOutData;

    spi_word_buffer txBuffer (
        .clock(clock),
        .rst_n(rst_n),
        .inValid(txInValid),
        .inReady(txInReady),
        .inData(txInData),
        .outValid(txOutValid),
        .outReady(txOutReady),
        .outData(txOutData)
    );

    spi_word_buffer rxBuffer (
        .clock(clock),
        .rst_n(rst_n),
        .inValid(rxInValid),
        .inReady(rxInReady),
        .inData(rxInData),
        .outValid(rxOutValid),
        .outReady(rxOutReady),
        .outData(rxOutData)
    );

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    logic [`SPI_SYNC_BITS-1:0] syncOut;
    logic extClk, pinClk, txSel, rxSel, serialIn;
    logic extPrev_q, clkPrev_q, selPrev_q, extPrev_d, clkPrev_d, selPrev_d;
    logic txSelAct, rxSelAct, tick, sRise, sFall, sStart, sEnd;

    spi_sync3 #(.W(`SPI_SYNC_BITS)) pinSync (
        .clock(clock),
        .rst_n(rst_n),
        .din({serialInPin, rxFrameSyncIn, txFrameSyncIn, txBitClockIn, sampleClockPin}),
        .dout(syncOut)
    );

    assign {serialIn, rxSel, txSel, pinClk, extClk} = syncOut;
    assign txSelAct = ctl_q[`CTL_TX_FS_POL] ? ~txSel : txSel;
    assign rxSelAct = ctl_q[`CTL_RX_FS_POL] ? ~rxSel : rxSel;
    // one tick per divider input period
    assign tick = ctl_q[`CTL_DIV_IN_SEL] | (extClk & ~extPrev_q);
    assign sRise = pinClk & ~clkPrev_q;
    assign sFall = ~pinClk & clkPrev_q;
    assign sStart = enable & stopMode & ~isMaster & txSelAct & ~selPrev_q;
    assign sEnd = ~txSelAct & selPrev_q;

    always_comb begin
        extPrev_d = extClk;
        clkPrev_d = pinClk;
        selPrev_d = txSelAct;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            extPrev_q <= 1'b0;
            clkPrev_q <= 1'b0;
            selPrev_q <= 1'b0;
        end else begin
            extPrev_q <= extPrev_d;
            clkPrev_q <= clkPrev_d;
            selPrev_q <= selPrev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit clock phase lengths in divider ticks
    phase_t halfDiv, oddSum, oddHalf, hTicks, lTicks, hRaw, lRaw, period;
    logic evenDiv;

    assign halfDiv = {2'b00, div_q[`DIV_BITS-1:1]};
    assign oddSum = {1'b0, div_q} + `SPI_ONE_TICK;
    assign oddHalf = {1'b0, oddSum[`SPI_PHASE_BITS-1:1]};
    assign evenDiv = ~div_q[0] & (div_q != '0);
    assign hRaw = evenDiv ? halfDiv + `SPI_ONE_TICK : oddHalf;
    assign lRaw = evenDiv ? halfDiv : oddHalf;
    // a phase shorter than one tick cannot be made, so it is stretched to one
    assign hTicks = (hRaw == '0) ? `SPI_ONE_TICK : hRaw;
    assign lTicks = (lRaw == '0) ? `SPI_ONE_TICK : lRaw;
    assign period = hTicks + lTicks;

    ////////////////////////////////////////////////////////////////////////////
    // master bit clock and select sequencer
    master_state_t mstState_q, mstState_d;
    phase_t phase_q, phase_d;
    logic [`SPI_EDGE_BITS-1:0] edge_q, edge_d;
    logic clkLevel_q, clkLevel_d;
    logic mStart, mEnd, mRise, mFall;

    always_comb begin
        mstState_d = mstState_q;
        phase_d = phase_q;
        edge_d = edge_q;
        clkLevel_d = clkLevel_q;
        mStart = 1'b0;
        mEnd = 1'b0;
        mRise = 1'b0;
        mFall = 1'b0;
        case (mstState_q)
            ST_IDLE: begin
                if (runMaster && txOutValid && rxInReady) begin
                    mStart = 1'b1;
                    mstState_d = ST_SHIFT;
                    edge_d = '0;
                    // delayed mode waits a full period before the first edge
                    phase_d = delayMode ? period : hTicks;
                end
            end
            ST_SHIFT: begin
                if (tick) begin
                    if (phase_q <= `SPI_ONE_TICK) begin
                        clkLevel_d = ~clkLevel_q;
                        mFall = clkLevel_q;
                        mRise = ~clkLevel_q;
                        edge_d = edge_q + 1'b1;
                        phase_d = clkLevel_q ? lTicks : hTicks;
                        if (edge_q == `SPI_LAST_EDGE) begin
                            mstState_d = ST_TAIL;
                        end
                    end else begin
                        phase_d = phase_q - `SPI_ONE_TICK;
                    end
                end
            end
            ST_TAIL: begin
                if (tick) begin
                    if (phase_q <= `SPI_ONE_TICK) begin
                        mstState_d = ST_IDLE;
                        mEnd = 1'b1;
                    end else begin
                        phase_d = phase_q - `SPI_ONE_TICK;
                    end
                end
            end
            default: begin
                mstState_d = ST_IDLE;
            end
        endcase
        if (!runMaster && mstState_q != ST_IDLE) begin
            mstState_d = ST_IDLE;
            mEnd = 1'b1;
            clkLevel_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mstState_q <= ST_IDLE;
            phase_q <= '0;
            edge_q <= '0;
            clkLevel_q <= 1'b1;
        end else begin
            mstState_q <= mstState_d;
            phase_q <= phase_d;
            edge_q <= edge_d;
            clkLevel_q <= clkLevel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shift engine shared by master and slave
    word_t txShift_q, txShift_d, rxShift_q, rxShift_d;
    logic [`SPI_BITCNT_BITS-1:0] bitCnt_q, bitCnt_d;
    logic pend_q, pend_d, active_q, active_d;
    logic riseEdge, fallEdge, sampleEdge, updateEdge, doSample, load;

    assign riseEdge = isMaster ? mRise : (sRise & active_q);
    assign fallEdge = isMaster ? mFall : (sFall & active_q);
    assign sampleEdge = delayMode ? fallEdge : riseEdge;
    assign updateEdge = delayMode ? riseEdge : fallEdge;
    assign doSample = sampleEdge & (bitCnt_q != `SPI_FULL_WORD) & (isMaster | rxSelAct);
    assign load = mStart | sStart;
    assign txOutReady = mStart | (sStart & txOutValid);
    assign rxInData = {rxShift_q[`SPI_WORD_BITS-2:0], serialIn};
    assign rxInValid = doSample & (bitCnt_q == `SPI_LAST_BIT);

    always_comb begin
        txShift_d = txShift_q;
        rxShift_d = rxShift_q;
        bitCnt_d = bitCnt_q;
        pend_d = pend_q;
        active_d = active_q;
        if (load) begin
            // slave with nothing queued sends zeros
            txShift_d = txOutValid ? txOutData : '0;
            bitCnt_d = '0;
            pend_d = 1'b0;
            active_d = 1'b1;
        end else begin
            if (doSample) begin
                rxShift_d = rxInData;
                bitCnt_d = bitCnt_q + 1'b1;
                pend_d = 1'b1;
            end
            if (updateEdge && pend_q && bitCnt_q != `SPI_FULL_WORD) begin
                txShift_d = {txShift_q[`SPI_WORD_BITS-2:0], 1'b0};
                pend_d = 1'b0;
            end
            if (mEnd || (sEnd && !isMaster)) begin
                active_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txShift_q <= '0;
            rxShift_q <= '0;
            bitCnt_q <= '0;
            pend_q <= 1'b0;
            active_q <= 1'b0;
        end else begin
            txShift_q <= txShift_d;
            rxShift_q <= rxShift_d;
            bitCnt_q <= bitCnt_d;
            pend_q <= pend_d;
            active_q <= active_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins
    assign serialOutPin = txShift_q[`SPI_WORD_BITS-1];
    assign serialOutOe = active_q;
    assign txBitClockOut = ctl_q[`CTL_TX_CLK_POL] ? clkLevel_q : ~clkLevel_q;
    assign txBitClockOe = ctl_q[`CTL_TX_CLK_DIR];
    // select is low (high with the frame sync polarity bit clear) for the whole word while the master sequencer runs
    assign txFrameSyncOut = ctl_q[`CTL_TX_FS_POL] ^ (mstState_q != ST_IDLE);
    assign txFrameSyncOe = ctl_q[`CTL_TX_FS_DIR];
    assign rxFrameSyncOut = ctl_q[`CTL_RX_FS_POL] ^ (mstState_q != ST_IDLE);
    assign rxFrameSyncOe = ctl_q[`CTL_RX_FS_DIR];

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write side
    logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bvalid_q, bvalid_d;
    logic [`AXI_ADDR_BITS-1:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d, laneMask;
    logic [3:0] wStrb_q, wStrb_d;
    logic [1:0] bresp_q, bresp_d;
    logic doWrite, overrunSet, underrunSet;

    assign awready = ~awHeld_q & ~bvalid_q;
    assign wready = ~wHeld_q & ~bvalid_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    // a data word waits here while the transmit buffer is full
    assign doWrite = awHeld_q & wHeld_q & ~bvalid_q & ((awAddr_q != `OFS_TXDATA) | txInReady);
    assign laneMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}}, {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
    assign txInValid = doWrite & (awAddr_q == `OFS_TXDATA) & wStrb_q[0];
    assign txInData = wData_q[`SPI_WORD_BITS-1:0];
    assign overrunSet = rxInValid & ~rxInReady;
    assign underrunSet = sStart & ~txOutValid;

    always_comb begin
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        bvalid_d = bvalid_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bresp_d = bresp_q;
        ctl_d = ctl_q;
        div_d = div_q;
        overrun_d = overrun_q;
        underrun_d = underrun_q;
        if (awvalid && awready) begin
            awHeld_d = 1'b1;
            awAddr_d = awaddr;
        end
        if (wvalid && wready) begin
            wHeld_d = 1'b1;
            wData_d = wdata;
            wStrb_d = wstrb;
        end
        if (doWrite) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = `RESP_OKAY;
            if (awAddr_q == `OFS_CONTROL) begin
                ctl_d = (ctl_q & ~laneMask[`CTL_BITS-1:0])
                    | (wData_q[`CTL_BITS-1:0] & laneMask[`CTL_BITS-1:0]);
            end else if (awAddr_q == `OFS_DIVIDER) begin
                if (wStrb_q[0]) begin
                    div_d = wData_q[`DIV_BITS-1:0];
                end
            end else if (awAddr_q == `OFS_STATUS) begin
                if (wStrb_q[0] && wData_q[`STS_OVERRUN]) begin
                    overrun_d = 1'b0;
                end
                if (wStrb_q[0] && wData_q[`STS_UNDERRUN]) begin
                    underrun_d = 1'b0;
                end
            end else if (awAddr_q != `OFS_TXDATA) begin
                bresp_d = `RESP_SLVERR;
            end
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        // a new event wins over a clear in the same cycle
        if (overrunSet) begin
            overrun_d = 1'b1;
        end
        if (underrunSet) begin
            underrun_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bvalid_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
            bresp_q <= `RESP_OKAY;
            ctl_q <= `CTL_RESET;
            div_q <= `DIV_RESET;
            overrun_q <= 1'b0;
            underrun_q <= 1'b0;
        end else begin
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            bvalid_q <= bvalid_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bresp_q <= bresp_d;
            ctl_q <= ctl_d;
            div_q <= div_d;
            overrun_q <= overrun_d;
            underrun_q <= underrun_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite read side
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic busy;

    assign busy = active_q | (mstState_q != ST_IDLE);
    assign arready = ~rvalid_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign rxOutReady = arvalid & arready & (araddr == `OFS_RXDATA);

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (arvalid && arready) begin
            rvalid_d = 1'b1;
            rresp_d = `RESP_OKAY;
            rdata_d = '0;
            if (araddr == `OFS_CONTROL) begin
                rdata_d[`CTL_BITS-1:0] = ctl_q;
            end else if (araddr == `OFS_DIVIDER) begin
                rdata_d[`DIV_BITS-1:0] = div_q;
            end else if (araddr == `OFS_TXDATA) begin
                rdata_d = '0;
            end else if (araddr == `OFS_RXDATA) begin
                rdata_d[`SPI_WORD_BITS-1:0] = rxOutValid ? rxOutData : '0;
            end else if (araddr == `OFS_STATUS) begin
                rdata_d[4:0] = {underrun_q, overrun_q, rxOutValid, ~txInReady, busy};
            end else begin
                rresp_d = `RESP_SLVERR;
            end
        end else if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end
endmodule // spi_port

// *** spi_port_assertions.sv ***
// checker for the clock-stop serial port pins and register bus
`timescale 1ns/1ps
`include "spi_port_params.svh"
module spi_port_assertions (
    // clock, reset and register bus
    input wire logic clock, rst_n, awvalid, awready, wvalid, wready, bvalid,
    input wire logic [7:0] awaddr, araddr,
    input wire logic arvalid, arready, rvalid,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    // link pins
    input wire logic txBitClockOut, txBitClockOe, txFrameSyncOut, txFrameSyncOe,
    input wire logic txFrameSyncIn, serialOutOe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_write_answer: assert property (awvalid && awready && wvalid && wready &&
        awaddr != `OFS_TXDATA |-> ##2 bvalid) else $error("write answer late");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_read_unmapped: assert property (arvalid && arready && araddr > 8'h10 |=>
        rresp == `RESP_SLVERR && rdata == 32'h0) else $error("unmapped read");
    a_lead_high: assert property ($fell(txFrameSyncOut) && txFrameSyncOe |->
        txBitClockOut ##1 txBitClockOut) else $error("select low without lead");
    a_tail_high: assert property ($rose(txFrameSyncOut) && txFrameSyncOe |->
        $past(txBitClockOut)) else $error("select released mid bit");
    a_clock_idle: assert property (txFrameSyncOe && txFrameSyncOut &&
        $past(txFrameSyncOut) |-> $stable(txBitClockOut)) else $error("clock moved idle");
    a_slave_drive: assert property ($fell(txFrameSyncIn) && !txBitClockOe |->
        ##[1:6] serialOutOe) else $error("slave output not driven");
    a_slave_release: assert property ($rose(txFrameSyncIn) && !txBitClockOe |->
        ##[1:6] !serialOutOe) else $error("slave output not released");
    cover property ($fell(txFrameSyncOut) && txFrameSyncOe);
    cover property ($rose(serialOutOe) && !txBitClockOe);
    cover property (rvalid && rresp == `RESP_SLVERR);
endmodule // spi_port_assertions

// *** spi_peer_model.sv ***
// spi slave peer for the port as master in mode 10b
`timescale 1ns/1ps
module spi_peer_model #(parameter logic [7:0] REPLY = 8'h3c) (
    // link pins
    input wire logic sclk, selN, mosi,
    // line driven and word seen
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] tx = 8'h00;
    initial miso = 1'b0;
    always @(negedge selN) tx = REPLY;
    // a released line inverts the last bit it showed
    always @(posedge selN) miso = ~miso;
    always @(negedge sclk) if (!selN) {miso, tx} = {tx, 1'b0};
    always @(posedge sclk) if (!selN) got = {got[6:0], mosi};
endmodule // spi_peer_model

// *** buffered_serial_port_spi_mode_tb.sv ***
// testbench of the clock-stop serial port
`timescale 1ns/1ps
`include "spi_port_params.svh"
module buffered_serial_port_spi_mode_tb;
    logic clock = '0, rst_n = '0, awvalid = '0, wvalid = '0, bready = '0, miso;
    logic arvalid = '0, rready = '0, sampleClockPin = '0, tbMosi = '0, slaveMode = '0;
    logic txBitClockIn = '1, txFrameSyncIn = '1;
    logic [7:0] awaddr = '0, araddr = '0, got;
    logic [31:0] wdata = '0, rdata, rv;
    logic [3:0] wstrb = 4'hf;
    wire logic rxFrameSyncIn = txFrameSyncIn;
    wire logic serialInPin = slaveMode ? tbMosi : miso;
    logic awready, wready, bvalid, arready, rvalid, txBitClockOut, txBitClockOe;
    logic txFrameSyncOut, txFrameSyncOe, rxFrameSyncOut, rxFrameSyncOe;
    logic serialOutPin, serialOutOe;
    logic [1:0] bresp, rresp, rr;
    int nErrors = 0, nChecks = 0;
    spi_port dut (.*);
    spi_peer_model #(.REPLY(8'h3c)) peer (.sclk(txBitClockOut), .selN(txFrameSyncOut),
        .mosi(serialOutPin), .miso(miso), .got(got));
    initial forever #5 clock = ~clock;
    initial begin
        #200us;
        nErrors++;
        stop_test;
    end
    task stop_test;
        $display("checks %0d errors %0d", nChecks, nErrors);
        if (nErrors == 0 && nChecks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, e);
        nChecks++;
        if (s !== e) begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        int n = 0;
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(negedge clock);
            {ha, hw, hb, rr} = {awvalid & awready, wvalid & wready, bvalid, bresp};
            @(posedge clock);
            if (ha) awvalid <= '0;
            if (hw) wvalid <= '0;
        end while (!hb && ++n < 300);
        chk("write answer", hb, 1'b1);
        bready <= '0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a);
        logic ha, hb;
        int n = 0;
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(negedge clock);
            {ha, hb, rv, rr} = {arready, rvalid, rdata, rresp};
            @(posedge clock);
            if (ha) arvalid <= '0;
        end while (!hb && ++n < 300);
        chk("read answer", hb, 1'b1);
        rready <= '0;
        @(posedge clock);
    endtask
    task automatic t_regs;
        rd(`OFS_CONTROL);
        chk("control", rv, 32'h07c);
        rd(`OFS_DIVIDER);
        chk("divider", rv, 32'h1);
        rd(8'h14);
        chk("unmapped read resp", rr, `RESP_SLVERR);
        chk("unmapped read data", rv, 32'h0);
        wr(8'h14, 32'h1);
        chk("unmapped write", rr, `RESP_SLVERR);
        $display("register test done");
    endtask
    task automatic t_master(input logic [7:0] d, w);
        int k = 0, lo = 0, hi = 0;
        wr(`OFS_DIVIDER, {24'h0, d});
        wr(`OFS_TXDATA, {24'h0, w});
        wr(`OFS_CONTROL, 32'h1fd);
        chk("select oe", {txBitClockOe, txFrameSyncOe, rxFrameSyncOe}, 3'b110);
        while (txBitClockOut !== 1'b0 && k++ < 99) @(negedge clock);
        while (txBitClockOut === 1'b0 && lo < 99) begin @(negedge clock); lo++; end
        while (txBitClockOut === 1'b1 && hi < 99) begin @(negedge clock); hi++; end
        chk("low phase", lo, d[0] ? (d + 1) / 2 : d / 2);
        chk("high phase", hi, d[0] ? (d + 1) / 2 : d / 2 + 1);
        chk("period", lo + hi, d + 1);
        while (txFrameSyncOut !== 1'b1 && k++ < 999) @(negedge clock);
        chk("select released", txFrameSyncOut, 1'b1);
        @(posedge clock);
        wr(`OFS_CONTROL, 32'h07c);
        chk("peer word", got, w);
        rd(`OFS_RXDATA);
        chk("master rx", rv, 32'h3c);
        $display("master test done");
    endtask
    task automatic t_buf;
        wr(`OFS_TXDATA, 32'h96);
        wr(`OFS_TXDATA, 32'h69);
        chk("write resp", rr, `RESP_OKAY);
        rd(`OFS_STATUS);
        chk("tx full", rv[1], 1'b1);
        $display("buffer test done");
    endtask
    task automatic t_slave;
        logic [7:0] s = 8'hc3, m;
        slaveMode <= '1;
        wr(`OFS_DIVIDER, 32'h1);
        wr(`OFS_CONTROL, 32'h07f);
        chk("slave oe", {txBitClockOe, txFrameSyncOe, rxFrameSyncOe}, 3'b000);
        txFrameSyncIn <= '0;
        repeat (8) @(posedge clock);
        chk("drive on select", serialOutOe, 1'b1);
        for (int i = 7; i >= 0; i--) begin
            tbMosi <= s[i];
            repeat (8) @(posedge clock);
            txBitClockIn <= '0;
            m[i] = serialOutPin;
            repeat (8) @(posedge clock);
            txBitClockIn <= '1;
        end
        repeat (8) @(posedge clock);
        txFrameSyncIn <= '1;
        repeat (8) @(posedge clock);
        chk("release", serialOutOe, 1'b0);
        chk("slave out", m, 8'h96);
        rd(`OFS_RXDATA);
        chk("slave rx", rv, 32'hc3);
        $display("slave test done");
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= '1;
        t_regs;
        t_master(8'h0a, 8'ha5);
        t_master(8'h09, 8'h5a);
        t_buf;
        t_slave;
        stop_test;
    end
endmodule // buffered_serial_port_spi_mode_tb
bind spi_port spi_port_assertions sva (.*);
